// file: hw/sarseq_conv_if.sv
`timescale 1ns/10ps
`default_nettype none

interface sarseq_conv_if;
    logic       run;
    logic       repeat_mode;
    logic       slow;
    logic       abort;
    logic       comp;
    logic       sample;
    logic       done;
    logic [7:0] dac;

    modport ctl (output run, repeat_mode, slow, abort, comp,
                 input  sample, done, dac);
    modport eng (input  run, repeat_mode, slow, abort, comp,
                 output sample, done, dac);
endinterface : sarseq_conv_if

`default_nettype wire

// file: hw/sarseq_engine.sv
`timescale 1ns/10ps
`default_nettype none

module sarseq_engine
    import sarseq_pkg::*;
(
    input wire logic    clk,
    input wire logic    reset_n,
    sarseq_conv_if.eng  cv
);

    sarseq_state_t state;
    logic [7:0]    elapsed;
    logic [7:0]    step_cnt;
    logic [3:0]    bits_left;
    logic [2:0]    bit_idx;

    function automatic logic [7:0] total_len(input logic slow);
        return slow ? SLOW_TOTAL : FAST_TOTAL;
    endfunction : total_len

    function automatic logic [7:0] sample_len(input logic slow);
        return slow ? SLOW_SAMPLE : FAST_SAMPLE;
    endfunction : sample_len

    // equal spacing of the eight decisions; spare cycles settle at the end
    function automatic logic [7:0] step_len(input logic slow);
        return 8'((total_len(slow) - sample_len(slow)) / SAR_BITS);
    endfunction : step_len

    wire logic last_cycle = (elapsed == total_len(cv.slow) - 8'd1);

    // ------------------------------------------------------------
    // phase sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= ST_IDLE;
            elapsed   <= 8'h00;
            cv.sample <= 1'b0;
            cv.done   <= 1'b0;
        end else begin
            cv.done <= 1'b0;
            if (cv.abort) begin
                state     <= ST_IDLE;
                elapsed   <= 8'h00;
                cv.sample <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        if (cv.run) begin
                            state     <= ST_SAMPLE;
                            elapsed   <= 8'h00;
                            cv.sample <= 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        elapsed <= elapsed + 8'd1;
                        if (elapsed == sample_len(cv.slow) - 8'd1) begin
                            state     <= ST_CONVERT;
                            cv.sample <= 1'b0;
                        end
                    end
                    ST_CONVERT: begin
                        elapsed <= elapsed + 8'd1;
                        // done leads one cycle: result lands on the last edge
                        if (elapsed == total_len(cv.slow) - 8'd2) begin
                            cv.done <= 1'b1;
                        end
                        if (last_cycle) begin
                            // no idle gap between repeated conversions
                            if (cv.run && cv.repeat_mode) begin
                                state     <= ST_SAMPLE;
                                elapsed   <= 8'h00;
                                cv.sample <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state     <= ST_IDLE;
                        cv.sample <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // successive approximation register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cv.dac    <= 8'h00;
            step_cnt  <= 8'h00;
            bits_left <= 4'h0;
            bit_idx   <= 3'd7;
        end else if (state == ST_SAMPLE && !cv.abort) begin
            cv.dac    <= 8'h80;
            step_cnt  <= 8'h00;
            bits_left <= 4'd8;
            bit_idx   <= 3'd7;
        end else if (state == ST_CONVERT && bits_left != 4'h0) begin
            if (step_cnt == step_len(cv.slow) - 8'd1) begin
                step_cnt  <= 8'h00;
                bits_left <= bits_left - 4'd1;
                bit_idx   <= bit_idx - 3'd1;
                cv.dac[bit_idx] <= cv.comp;
                if (bit_idx != 3'd0) begin
                    cv.dac[bit_idx - 3'd1] <= 1'b1;
                end
            end else begin
                step_cnt <= step_cnt + 8'd1;
            end
        end
    end

endmodule : sarseq_engine

`default_nettype wire

// file: hw/sarseq_pkg.sv
package sarseq_pkg;

    // ------------------------------------------------------------
    // register map (indices; byte address is four times the index)
    // ------------------------------------------------------------
    localparam int          N_INST       = 2;
    localparam logic [7:0]  IDX_RESULT0  = 8'hf0;
    localparam logic [7:0]  IDX_CTRL0    = 8'hf1;
    localparam logic [7:0]  IDX_INTSEL0  = 8'hf2;
    localparam logic [7:0]  IDX_RESULT1  = 8'hf8;
    localparam logic [7:0]  IDX_CTRL1    = 8'hf9;
    localparam logic [7:0]  IDX_INTSEL1  = 8'hfa;
    localparam logic [1:0]  RSEL_RESULT  = 2'h0;
    localparam logic [1:0]  RSEL_CTRL    = 2'h1;
    localparam logic [1:0]  RSEL_INTSEL  = 2'h2;

    // ------------------------------------------------------------
    // control_logic_register fields and reset values
    // ------------------------------------------------------------
    localparam int          CH_MSB       = 7;
    localparam int          CH_LSB       = 5;
    localparam int          SPEED_BIT    = 4;
    localparam int          TRG_BIT      = 3;
    localparam int          POW_BIT      = 2;
    localparam int          CONT_BIT     = 1;
    localparam int          STR_BIT      = 0;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  RESULT_RESET = 8'h00;
    localparam logic        INTSEL_RESET = 1'b1;

    // ------------------------------------------------------------
    // conversion timing in internal system clock periods
    // ------------------------------------------------------------
    localparam logic [7:0]  FAST_TOTAL   = 8'd78;
    localparam logic [7:0]  FAST_SAMPLE  = 8'd48;
    localparam logic [7:0]  SLOW_TOTAL   = 8'd138;
    localparam logic [7:0]  SLOW_SAMPLE  = 8'd84;
    localparam logic [7:0]  SAR_BITS     = 8'd8;
    localparam logic [1:0]  IRQ_LOW_CYC  = 2'd2;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10
    } sarseq_state_t;

endpackage : sarseq_pkg

// file: hw/sarseq_top.sv
`timescale 1ns/10ps
`default_nettype none

module sarseq_top
    import sarseq_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic [11:0]            paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   halt_active,
    input  wire logic [N_INST-1:0]      external_trigger_pin,
    input  wire logic [N_INST-1:0]      internal_trigger_event,
    input  wire logic [N_INST-1:0]      comparator_in,
    input  wire logic [N_INST-1:0]      ext_irq_pin,
    output wire logic [N_INST-1:0][2:0] channel_select,
    output wire logic [N_INST-1:0]      analog_bias_enable,
    output wire logic [N_INST-1:0]      sample_hold,
    output wire logic [N_INST-1:0][7:0] dac_trial,
    output wire logic [N_INST-1:0]      irq_channel
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // {hit, instance, register select}
    function automatic logic [3:0] decode(input logic [11:0] addr);
        logic [7:0] idx;
        logic       hit;
        idx = addr[9:2];
        hit = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00) &&
              (idx[7:4] == IDX_RESULT0[7:4]) &&
              (idx[2:0] <= IDX_INTSEL0[2:0]);
        return {hit, idx[3], idx[1:0]};
    endfunction : decode

    wire logic [3:0] dec     = decode(paddr);
    wire logic       dec_hit = dec[3];
    wire logic       dec_ins = dec[2];
    wire logic [1:0] dec_reg = dec[1:0];
    wire logic       wr_take = psel && penable && pready && pwrite;

    logic [7:0] ctrl   [N_INST];
    logic [7:0] result [N_INST];
    logic       intsel [N_INST];

    // ------------------------------------------------------------
    // apb slave: zero wait, answer prepared in the setup cycle
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (dec_hit) begin
            unique case (dec_reg)
                RSEL_RESULT: rd_byte = result[dec_ins];
                RSEL_CTRL:   rd_byte = ctrl[dec_ins];
                RSEL_INTSEL: rd_byte = {7'h00, intsel[dec_ins]};
                default:     rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !dec_hit;
            if (psel && !penable) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // per-converter sequencing
    // ------------------------------------------------------------
    for (genvar i = 0; i < N_INST; i++) begin : g_conv
        sarseq_conv_if cv ();

        logic       ext_prev;
        logic       str_prev;
        logic [1:0] irq_cnt;
        logic [1:0] next_irq_cnt;
        logic       irq_out;

        wire logic sel_me   = dec_hit && (dec_ins == 1'(i));
        wire logic wr_ctrl  = wr_take && sel_me && (dec_reg == RSEL_CTRL);
        wire logic wr_res   = wr_take && sel_me && (dec_reg == RSEL_RESULT);
        wire logic wr_isel  = wr_take && sel_me && (dec_reg == RSEL_INTSEL);
        wire logic ext_fall = ext_prev && !external_trigger_pin[i];
        wire logic trig_now = ext_fall || internal_trigger_event[i];
        // pin held low or event high counts as an already active trigger
        wire logic trig_lvl = !external_trigger_pin[i] ||
                              internal_trigger_event[i];
        wire logic trig_hit = ctrl[i][TRG_BIT] && !ctrl[i][STR_BIT] &&
                              trig_now;
        wire logic str_fell = str_prev && !ctrl[i][STR_BIT];

        // control register: write wins over hardware except halt, which still clears
        // the bias bit; a trigger seen in the write cycle is folded in so it is not lost
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                ctrl[i] <= CTRL_RESET;
            end else if (wr_ctrl) begin
                ctrl[i] <= pwdata[7:0];
                if (pwdata[TRG_BIT] &&
                    ((!ctrl[i][TRG_BIT] && trig_lvl) || trig_now)) begin
                    ctrl[i][STR_BIT] <= 1'b1;
                end
                if (halt_active) begin
                    ctrl[i][POW_BIT] <= 1'b0;
                end
            end else begin
                if (halt_active) begin
                    ctrl[i][POW_BIT] <= 1'b0;
                end
                if (trig_hit) begin
                    ctrl[i][STR_BIT] <= 1'b1;
                end else if (cv.done && !ctrl[i][CONT_BIT]) begin
                    ctrl[i][STR_BIT] <= 1'b0;
                end
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                result[i] <= RESULT_RESET;
            end else if (cv.done && !cv.abort) begin
                result[i] <= cv.dac;
            end else if (wr_res) begin
                result[i] <= pwdata[7:0];
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                intsel[i] <= INTSEL_RESET;
            end else if (wr_isel) begin
                intsel[i] <= pwdata[0];
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                ext_prev <= 1'b1;
            end else begin
                ext_prev <= external_trigger_pin[i];
            end
        end

        // engine: a write aborts, a stopped flag or bias off holds it idle
        assign cv.abort       = wr_ctrl;
        assign cv.run         = ctrl[i][STR_BIT] &&
                                ctrl[i][POW_BIT];
        assign cv.repeat_mode = ctrl[i][CONT_BIT];
        assign cv.slow        = ctrl[i][SPEED_BIT];
        assign cv.comp        = comparator_in[i];

        sarseq_engine u_engine (
            .clk     (clk),
            .reset_n (reset_n),
            .cv      (cv.eng)
        );

        // ------------------------------------------------------------
        // shared interrupt channel
        // ------------------------------------------------------------
        always_comb begin
            next_irq_cnt = irq_cnt;
            if (str_fell && intsel[i]) begin
                next_irq_cnt = IRQ_LOW_CYC;
            end else if (irq_cnt != 2'd0) begin
                next_irq_cnt = irq_cnt - 2'd1;
            end
        end

        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                str_prev <= 1'b0;
                irq_cnt  <= 2'd0;
                irq_out  <= 1'b1;
            end else begin
                str_prev <= ctrl[i][STR_BIT];
                irq_cnt  <= next_irq_cnt;
                irq_out  <= intsel[i] ? (next_irq_cnt == 2'd0)
                                      : ext_irq_pin[i];
            end
        end

        assign channel_select[i]     = ctrl[i][CH_MSB:CH_LSB];
        assign analog_bias_enable[i] = ctrl[i][POW_BIT];
        assign sample_hold[i]        = cv.sample;
        assign dac_trial[i]          = cv.dac;
        assign irq_channel[i]        = irq_out;
    end

endmodule : sarseq_top

`default_nettype wire

// file: verif/sarseq_analog_model.sv
`timescale 1ns/10ps
`default_nettype none

module sarseq_analog_model
    import sarseq_pkg::*;
(
    input  wire logic [N_INST-1:0][2:0] channel_select,
    input  wire logic [N_INST-1:0][7:0] dac_trial,
    input  wire logic [N_INST-1:0]      sample_hold,
    output var  logic [N_INST-1:0]      comparator_in
);
    // ------
    // fixed analog level per channel
    // ------
    // output means nothing while sampling, so it wanders with the trial
    always_comb begin
        for (int i = 0; i < N_INST; i++) begin
            comparator_in[i] = sample_hold[i] ? ~dac_trial[i][0] :
                (({channel_select[i], 5'h13} ^ (i == 1 ? 8'h5a : 8'h00))
                 >= dac_trial[i]);
        end
    end
endmodule : sarseq_analog_model

`default_nettype wire

// file: verif/sarseq_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module sarseq_top_asserts
    import sarseq_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic [11:0]            paddr,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic                   halt_active,
    input wire logic [N_INST-1:0]      ext_irq_pin,
    input wire logic [N_INST-1:0][2:0] channel_select,
    input wire logic [N_INST-1:0]      analog_bias_enable,
    input wire logic [N_INST-1:0]      sample_hold,
    input wire logic [N_INST-1:0]      irq_channel
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ------
    // shadows of the first converter
    // ------
    logic       wc;
    logic       wi;
    logic       spd;
    logic       isel;
    logic [7:0] cnt;

    assign wc = psel && penable && pwrite && pready && paddr == 12'h3c4;
    assign wi = psel && penable && pwrite && pready && paddr == 12'h3c8;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spd  <= 1'b0;
            isel <= INTSEL_RESET;
            cnt  <= 8'h00;
        end else begin
            spd  <= wc ? pwdata[SPEED_BIT] : spd;
            isel <= wi ? pwdata[0] : isel;
            cnt  <= sample_hold[0] ? cnt + 8'h01 : 8'h00;
        end
    end

    a_chan_write: assert property (
        wc |=> channel_select[0] == $past(pwdata[7:5]))
        else $error("channel select not as written");
    a_chan_hold: assert property (
        !wc |=> $stable(channel_select[0]))
        else $error("channel select moved without a write");
    a_bias_write: assert property (
        wc && !halt_active |=> analog_bias_enable[0] == $past(pwdata[2]))
        else $error("bias enable not as written");
    a_halt_bias: assert property (
        halt_active |=> analog_bias_enable == 2'b00)
        else $error("bias enable kept during halt");
    a_sample_len: assert property (
        $fell(sample_hold[0]) && !$past(wc) && !$past(halt_active)
        |-> cnt == (spd ? SLOW_SAMPLE : FAST_SAMPLE))
        else $error("sampling phase has wrong length");
    a_write_abort: assert property (
        wc |=> !sample_hold[0])
        else $error("sampling survived a control write");
    a_irq_pulse: assert property (
        isel && $fell(irq_channel[0]) |=> !irq_channel[0] ##1 irq_channel[0])
        else $error("interrupt low pulse has wrong length");
    a_irq_route: assert property (
        !isel |=> irq_channel[0] == $past(ext_irq_pin[0]))
        else $error("interrupt line does not follow pin");

    c_fast: cover property ($fell(sample_hold[0]) && !spd);
    c_slow: cover property ($fell(sample_hold[0]) && spd);
    c_halt: cover property (halt_active && analog_bias_enable[0]);
endmodule : sarseq_top_asserts

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb
    import sarseq_pkg::*;
;
    // ------
    // signals
    // ------
    logic            clk = 1'b0;
    logic            reset_n = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic            halt = 1'b0;
    logic            pready, pslverr, er;
    logic [11:0]     paddr = 12'h000;
    logic [31:0]     pwdata = 32'h0;
    logic [31:0]     prdata, rd;
    logic [1:0]      ext_pin = 2'h3;
    logic [1:0]      evt = 2'h0;
    logic [1:0]      irq_pin = 2'h3;
    logic [1:0]      cmp, bias, sh, irq;
    logic [1:0][2:0] chsel;
    logic [1:0][7:0] dac;
    int              errors = 0;
    int              checks = 0;
    int              cyc = 0;

    sarseq_top dut_u (.clk(clk), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_active(halt), .external_trigger_pin(ext_pin),
        .internal_trigger_event(evt), .comparator_in(cmp),
        .ext_irq_pin(irq_pin), .channel_select(chsel),
        .analog_bias_enable(bias), .sample_hold(sh), .dac_trial(dac),
        .irq_channel(irq));
    sarseq_analog_model ana_u (.channel_select(chsel), .dac_trial(dac),
        .sample_hold(sh), .comparator_in(cmp));

    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            errors = errors + 1;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    function automatic logic [11:0] ad(input int i, input int r);
        return {2'b00, IDX_RESULT0 + 8'(8 * i + r), 2'b00};
    endfunction : ad

    function automatic logic [7:0] lvl(input int i, input logic [2:0] c);
        return {c, 5'h13} ^ (i == 1 ? 8'h5a : 8'h00);
    endfunction : lvl

    // one idle cycle after each access so no signal is assigned twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rc(input string n, input logic [11:0] a,
                      input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(n, rd, {24'h0, e});
        chk(n, er, 1'b0);
    endtask : rc

    // edges until the line is seen to fall from high to low, and sampling cycles meanwhile
    task automatic wait_irq(input int i, output int m, output int s);
        logic p;
        m = 0;
        s = 0;
        do begin
            p = irq[i];
            @(posedge clk);
            m++;
            s += sh[i];
        end while ((p !== 1'b1 || irq[i] !== 1'b0) && m < 200);
    endtask : wait_irq

    task automatic pulse(input logic e);
        if (e) ext_pin[0] <= 1'b0;
        else evt[0] <= 1'b1;
        repeat (2) @(posedge clk);
        ext_pin[0] <= 1'b1;
        evt[0]     <= 1'b0;
        @(posedge clk);
    endtask : pulse

    task automatic t_regs;
        for (int i = 0; i < 2; i++) begin
            rc("result", ad(i, 0), RESULT_RESET);
            rc("ctrl", ad(i, 1), 8'h00);
            rc("isel", ad(i, 2), 8'h01);
        end
        apb(1'b1, ad(1, 1), 8'hfa);
        rc("ctrl all", ad(1, 1), 8'hfa);
        apb(1'b1, ad(0, 0), 8'h5c);
        rc("result wr", ad(0, 0), 8'h5c);
        apb(1'b1, 12'h3d0, 8'hff);
        chk("reserved wr", er, 1'b1);
        apb(1'b0, 12'h3ec, 8'h00);
        chk("reserved rd", rd, 32'h0);
        chk("reserved rd err", er, 1'b1);
    endtask : t_regs

    task automatic t_conv(input int i, input logic [7:0] c);
        int m, s;
        apb(1'b1, ad(i, 1), c);
        wait_irq(i, m, s);
        chk("cycles", m, c[4] ? 140 : 80);
        chk("sampling", s, c[4] ? 84 : 48);
        chk("channel", chsel[i], c[7:5]);
        rc("result", ad(i, 0), lvl(i, c[7:5]));
        rc("ctrl", ad(i, 1), c & 8'hfe);
    endtask : t_conv

    task automatic t_trig;
        int m, s;
        apb(1'b1, ad(0, 1), 8'h4c);
        pulse(1'b1);
        wait_irq(0, m, s);
        chk("pin start", m >= 76 && m <= 84, 1'b1);
        rc("trig result", ad(0, 0), lvl(0, 3'h2));
        pulse(1'b0);
        repeat (20) @(posedge clk);
        pulse(1'b1);
        wait_irq(0, m, s);
        chk("event start", m >= 54 && m <= 62, 1'b1);
        wait_irq(0, m, s);
        chk("late trigger", m, 200);
        rc("trig ctrl", ad(0, 1), 8'h4c);
        apb(1'b1, ad(0, 1), 8'h04);
        pulse(1'b1);
        pulse(1'b0);
        ext_pin[0] <= 1'b0;
        wait_irq(0, m, s);
        chk("disabled", m + s, 200);
        apb(1'b1, ad(0, 1), 8'h0c);
        wait_irq(0, m, s);
        chk("active at enable", m >= 78 && m <= 84, 1'b1);
        ext_pin[0] <= 1'b1;
    endtask : t_trig

    task automatic t_cont;
        int m, s;
        apb(1'b1, ad(0, 1), 8'h07);
        wait_irq(0, m, s);
        chk("cont running", m, 200);
        chk("cont sampling", s, 140);
        apb(1'b1, ad(0, 1), 8'h06);
        wait_irq(0, m, s);
        chk("stop irq", m <= 3, 1'b1);
        rc("cont result", ad(0, 0), lvl(0, 3'h0));
        apb(1'b1, ad(0, 1), 8'h45);
        repeat (40) @(posedge clk);
        apb(1'b1, ad(0, 1), 8'ha5);
        wait_irq(0, m, s);
        chk("abort restart", m, 80);
        chk("abort sampling", s, 48);
    endtask : t_cont

    task automatic t_misc;
        int m, s;
        apb(1'b1, ad(1, 1), 8'h04);
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("bias pins", bias, 2'b00);
        rc("halt ctrl", ad(1, 1), 8'h00);
        apb(1'b1, ad(0, 2), 8'h00);
        irq_pin[0] <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pin route", irq[0], 1'b0);
        irq_pin[0] <= 1'b1;
        rc("isel", ad(0, 2), 8'h00);
        apb(1'b1, ad(0, 1), 8'h05);
        wait_irq(0, m, s);
        chk("converter masked", m, 200);
        apb(1'b1, ad(0, 2), 8'h01);
    endtask : t_misc

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_regs();
        apb(1'b1, ad(0, 1), 8'h04);
        apb(1'b1, ad(1, 1), 8'h04);
        repeat (1500) @(posedge clk);
        for (int c = 0; c < 8; c++) begin  // fast timing, channels 0 to 7 on alternating instances
            t_conv(c % 2, {3'(c), 5'h05});
        end
        t_conv(0, 8'hf5);
        t_conv(1, 8'h35);
        t_trig();
        t_cont();
        t_misc();
        final_report();
    end
endmodule : tb

bind sarseq_top sarseq_top_asserts chk_u (.clk(clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .halt_active(halt_active),
    .ext_irq_pin(ext_irq_pin), .channel_select(channel_select),
    .analog_bias_enable(analog_bias_enable), .sample_hold(sample_hold),
    .irq_channel(irq_channel));

`default_nettype wire
